// ===== dcs_top.sv
// dcs_top: eight-channel dma addressing, transfer counting and shared status
// assumes apb master on sys_clk_in; requests and collision events come from logic on the same clock
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module dcs_top (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // peripheral side
    input  wire logic [7:0]        req_in,
    input  wire logic [7:0]        periph_coll_in,
    input  wire logic [7:0]        ram_coll_in,
    output dcs_pkg::dcs_xfer_t     xfer_out,
    output logic                   irq_out
);

    dcs_pkg::dcs_ctrl_t ctrl_r [dcs_pkg::NUM_CH];
    logic [15:0]        pad_r  [dcs_pkg::NUM_CH];
    logic [9:0]         cnt_r  [dcs_pkg::NUM_CH];
    logic [15:0]        sta_r  [dcs_pkg::NUM_CH];
    logic [15:0]        stb_r  [dcs_pkg::NUM_CH];
    logic [9:0]         done_r [dcs_pkg::NUM_CH];
    logic [15:0]        ofs_r  [dcs_pkg::NUM_CH];
    logic [7:0]         buffer_select_status_r;
    logic [7:0]         pend_r;
    logic [7:0]         pcol_r;
    logic [7:0]         xcol_r;
    logic [7:0]         istat_r;
    logic [7:0]         imask_r;
    logic [3:0]         last_ch_r;
    logic [15:0]        recent_r;
    logic [31:0]        prdata_r;
    dcs_pkg::dcs_xfer_t xfer_r;

    // bus decode
    wire        setup_rd  = psel_in & ~penable_in & ~pwrite_in;
    wire        acc       = psel_in & penable_in;
    wire        wr        = acc & pwrite_in;
    wire        rd        = acc & ~pwrite_in;
    wire        ch_area   = paddr_in[11:8] == dcs_pkg::CH_AREA;
    wire [2:0]  sel_ch    = paddr_in[7:dcs_pkg::CH_SEL_LSB];
    wire [4:0]  ch_ofs    = paddr_in[4:0];
    wire        hit_ctrl  = ch_area & (ch_ofs == dcs_pkg::OFF_CTRL);
    wire        hit_pad   = ch_area & (ch_ofs == dcs_pkg::OFF_PAD);
    wire        hit_cnt   = ch_area & (ch_ofs == dcs_pkg::OFF_CNT);
    wire        hit_sta   = ch_area & (ch_ofs == dcs_pkg::OFF_STA);
    wire        hit_stb   = ch_area & (ch_ofs == dcs_pkg::OFF_STB);
    wire        hit_coll  = paddr_in == dcs_pkg::OFF_COLL;
    wire        hit_buf   = paddr_in == dcs_pkg::OFF_BUFSTAT;
    wire        hit_rec   = paddr_in == dcs_pkg::OFF_RECENT;
    wire        hit_istat = paddr_in == dcs_pkg::OFF_ISTAT;
    wire        hit_imask = paddr_in == dcs_pkg::OFF_IMASK;
    wire        hit_any   = hit_ctrl | hit_pad | hit_cnt | hit_sta | hit_stb
                          | hit_coll | hit_buf | hit_rec | hit_istat | hit_imask;

    function automatic logic [15:0] ctrl_word(input dcs_pkg::dcs_ctrl_t c);
        ctrl_word = {c.en, c.byte_size, c.dir, c.half, c.nullw, 5'h00, c.amode, 2'h0, c.mode};
    endfunction

    function automatic dcs_pkg::dcs_ctrl_t word_ctrl(input logic [15:0] w);
        dcs_pkg::dcs_ctrl_t c;
        c.en        = w[15];
        c.byte_size = w[14];
        c.dir       = w[13];
        c.half      = w[12];
        c.nullw     = w[11];
        c.amode     = w[5:4];
        c.mode      = dcs_pkg::dcs_mode_t'(w[1:0]);
        word_ctrl   = c;
    endfunction

    // read selection, captured in the setup cycle
    wire [15:0] ch_word = hit_ctrl ? ctrl_word(ctrl_r[sel_ch])
                        : hit_pad  ? pad_r[sel_ch]
                        : hit_cnt  ? {6'h00, cnt_r[sel_ch]}
                        : hit_sta  ? sta_r[sel_ch]
                        : hit_stb  ? stb_r[sel_ch]
                        : 16'h0000;
    wire [15:0] sh_word = hit_coll  ? {pcol_r, xcol_r}
                        : hit_buf   ? {4'h0, last_ch_r, buffer_select_status_r}
                        : hit_rec   ? recent_r
                        : hit_istat ? {8'h00, istat_r}
                        : hit_imask ? {8'h00, imask_r}
                        : 16'h0000;

    assign pready_out  = acc;
    assign pslverr_out = acc & ~hit_any;
    assign prdata_out  = prdata_r;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_r <= {16'h0000, ch_word | sh_word};
        end
    end

    // arbitration: lowest enabled channel with a pending request
    logic [7:0] en_vec;
    logic [2:0] gch;
    always_comb begin
        gch = 3'h0;
        for (int i = dcs_pkg::NUM_CH - 1; i >= 0; i--) begin
            en_vec[i] = ctrl_r[i].en;
            if (pend_r[i] && ctrl_r[i].en) begin
                gch = 3'(i);
            end
        end
    end

    wire                    gnt_valid = |(pend_r & en_vec);
    dcs_pkg::dcs_ctrl_t     gctrl;
    assign gctrl = ctrl_r[gch];
    wire [15:0] gbase    = buffer_select_status_r[gch] ? stb_r[gch] : sta_r[gch];
    wire [15:0] gram     = gbase + ofs_r[gch];
    wire [15:0] gstep    = (gctrl.amode != dcs_pkg::AMODE_POSTINC) ? 16'h0000
                         : gctrl.byte_size ? dcs_pkg::STEP_BYTE : dcs_pkg::STEP_WORD;
    wire        glast    = done_r[gch] == cnt_r[gch];
    wire        ghalf    = done_r[gch] == (cnt_r[gch] >> 1);
    wire        gpp      = (gctrl.mode == dcs_pkg::MODE_CONT_PP) | (gctrl.mode == dcs_pkg::MODE_ONESHOT_PP);
    wire        gstop    = (gctrl.mode == dcs_pkg::MODE_ONESHOT)
                         | ((gctrl.mode == dcs_pkg::MODE_ONESHOT_PP) & buffer_select_status_r[gch]);
    wire        gblk_evt = gnt_valid & (gctrl.half ? ghalf : glast);
    wire [7:0]  srv_vec  = gnt_valid ? 8'(8'h01 << gch) : 8'h00;
    wire [7:0]  blk_set  = gblk_evt ? srv_vec : 8'h00;

    // per-channel registers and block progress
    always_ff @(posedge sys_clk_in) begin
        for (int n = 0; n < dcs_pkg::NUM_CH; n++) begin
            if (!reset_n_in) begin
                ctrl_r[n] <= dcs_pkg::CTRL_RST;
                pad_r[n]  <= dcs_pkg::WORD16_RST;
                cnt_r[n]  <= dcs_pkg::CNT_RST;
                sta_r[n]  <= dcs_pkg::WORD16_RST;
                stb_r[n]  <= dcs_pkg::WORD16_RST;
                done_r[n] <= dcs_pkg::CNT_RST;
                ofs_r[n]  <= dcs_pkg::WORD16_RST;
                buffer_select_status_r[n] <= 1'b0;
            end else begin
                if (wr && sel_ch == 3'(n)) begin
                    if (hit_pad) pad_r[n] <= pwdata_in[15:0];
                    if (hit_cnt) cnt_r[n] <= pwdata_in[9:0];
                    if (hit_sta) sta_r[n] <= pwdata_in[15:0];
                    if (hit_stb) stb_r[n] <= pwdata_in[15:0];
                end
                if (wr && hit_ctrl && sel_ch == 3'(n)) begin
                    // a new control word restarts the block at the primary buffer
                    ctrl_r[n] <= word_ctrl(pwdata_in[15:0]);
                    done_r[n] <= dcs_pkg::CNT_RST;
                    ofs_r[n]  <= dcs_pkg::WORD16_RST;
                    buffer_select_status_r[n] <= 1'b0;
                end else if (srv_vec[n]) begin
                    if (glast) begin
                        done_r[n] <= dcs_pkg::CNT_RST;
                        ofs_r[n]  <= dcs_pkg::WORD16_RST;
                        if (gpp) buffer_select_status_r[n] <= ~buffer_select_status_r[n];
                        if (gstop) ctrl_r[n].en <= 1'b0;
                    end else begin
                        done_r[n] <= done_r[n] + 10'h001;
                        ofs_r[n]  <= ofs_r[n] + gstep;
                    end
                end
            end
        end
    end

    // shared status, pending requests, interrupts
    wire [7:0] istat_clr = (rd && hit_istat) ? prdata_r[7:0] : 8'h00;
    wire [7:0] pcol_keep = (wr && hit_coll) ? pwdata_in[15:8] : 8'hff;
    wire [7:0] xcol_keep = (wr && hit_coll) ? pwdata_in[7:0] : 8'hff;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            pend_r    <= dcs_pkg::BYTE_RST;
            pcol_r    <= dcs_pkg::BYTE_RST;
            xcol_r    <= dcs_pkg::BYTE_RST;
            istat_r   <= dcs_pkg::BYTE_RST;
            imask_r   <= dcs_pkg::BYTE_RST;
            last_ch_r <= dcs_pkg::LAST_CH_RST;
            recent_r  <= dcs_pkg::WORD16_RST;
        end else begin
            pend_r  <= ((pend_r & ~srv_vec) | req_in) & en_vec;
            pcol_r  <= (pcol_r & pcol_keep) | periph_coll_in;
            xcol_r  <= (xcol_r & xcol_keep) | ram_coll_in;
            istat_r <= (istat_r & ~istat_clr) | blk_set;
            if (wr && hit_imask) imask_r <= pwdata_in[7:0];
            if (gnt_valid) begin
                last_ch_r <= {1'b0, gch};
                recent_r  <= gram;
            end
        end
    end

    // transfer issue
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            xfer_r <= '0;
        end else begin
            xfer_r.valid <= gnt_valid;
            if (gnt_valid) begin
                xfer_r.chan        <= gch;
                xfer_r.ram_addr    <= gram;
                xfer_r.periph_addr <= pad_r[gch];
                xfer_r.dir         <= gctrl.dir;
                xfer_r.byte_size   <= gctrl.byte_size;
                xfer_r.nullw       <= gctrl.nullw & ~gctrl.dir;
            end
        end
    end

    assign xfer_out = xfer_r;
    assign irq_out  = |(istat_r & imask_r);

    // checks
    a_pad_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr && hit_pad |=> pad_r[$past(sel_ch)] == $past(pwdata_in[15:0]))
        else $error("target address write not stored");

    a_cnt_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        setup_rd && hit_cnt |=> prdata_r[31:10] == 22'h0 && prdata_r[9:0] == cnt_r[$past(sel_ch)])
        else $error("count read shows wrong bits");

    a_block_length: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && !(wr && hit_ctrl) && !glast |=> done_r[$past(gch)] == $past(done_r[gch]) + 10'h001)
        else $error("transfer count did not advance");

    a_pcol_set: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        periph_coll_in != 8'h00 |=> (pcol_r & $past(periph_coll_in)) == $past(periph_coll_in))
        else $error("peripheral collision not flagged");

    a_xcol_sticky: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !(wr && hit_coll) |=> (xcol_r & $past(xcol_r)) == $past(xcol_r))
        else $error("ram collision flag lost without a write");

    a_coll_clear_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr && hit_coll && ram_coll_in == 8'h00 |=> xcol_r == ($past(xcol_r) & $past(pwdata_in[7:0])))
        else $error("collision clear wrong");

    a_last_ch_track: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        xfer_r.valid |-> last_ch_r == {1'b0, xfer_r.chan} && recent_r == xfer_r.ram_addr)
        else $error("last channel or recent address mismatch");

    a_last_ch_idle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !gnt_valid |=> last_ch_r == $past(last_ch_r) && last_ch_r != 4'h8)
        else $error("last channel changed without transfer");

    a_recent_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !gnt_valid ##1 !gnt_valid |=> recent_r == $past(recent_r, 2))
        else $error("recent address moved while idle");

    a_buffer_select_status_toggle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && glast && gpp && !(wr && hit_ctrl) |=> buffer_select_status_r[$past(gch)] != $past(buffer_select_status_r[gch]))
        else $error("buffer select did not swap");

    a_oneshot_stop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && glast && gstop && !(wr && hit_ctrl) |=> !ctrl_r[$past(gch)].en)
        else $error("one-shot channel still enabled");

    a_dir_carry: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid |=> xfer_r.valid && xfer_r.dir == $past(gctrl.dir) && xfer_r.periph_addr == $past(pad_r[gch]))
        else $error("transfer direction or address wrong");

    a_block_event: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && (gctrl.half ? ghalf : glast) |=> istat_r[$past(gch)])
        else $error("block event not recorded");

    a_enable_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid |-> ctrl_r[gch].en && pend_r[gch])
        else $error("disabled channel served");

    a_last_ch_legal: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        last_ch_r == dcs_pkg::LAST_CH_RST || !last_ch_r[3])
        else $error("last channel holds a reserved code");

    a_cnt_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr && hit_cnt |=> cnt_r[$past(sel_ch)] == $past(pwdata_in[9:0]))
        else $error("count write not stored");

    a_pcol_sticky: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !(wr && hit_coll) |=> (pcol_r & $past(pcol_r)) == $past(pcol_r))
        else $error("peripheral collision flag lost");

    a_xcol_set: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ram_coll_in != 8'h00 |=> (xcol_r & $past(ram_coll_in)) == $past(ram_coll_in))
        else $error("ram collision not flagged");

    a_pcol_clear_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr && hit_coll && periph_coll_in == 8'h00 |=> pcol_r == ($past(pcol_r) & $past(pwdata_in[15:8])))
        else $error("peripheral collision clear wrong");

    a_buffer_base: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && done_r[gch] == dcs_pkg::CNT_RST |-> gram == (buffer_select_status_r[gch] ? stb_r[gch] : sta_r[gch]))
        else $error("block not at selected buffer");

    a_buffer_select_status_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !gnt_valid && !(wr && hit_ctrl) |=> buffer_select_status_r == $past(buffer_select_status_r))
        else $error("buffer select moved while idle");

    a_ctrl_restart: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr && hit_ctrl |=> done_r[$past(sel_ch)] == dcs_pkg::CNT_RST && !buffer_select_status_r[$past(sel_ch)])
        else $error("control write did not restart");

    a_istat_read_clear: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        rd && hit_istat && blk_set == 8'h00 |=> (istat_r & $past(prdata_r[7:0])) == 8'h00)
        else $error("status read did not clear");

    c_oneshot_end: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && glast && gstop);
    c_pingpong: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && glast && gpp && buffer_select_status_r[gch]);
    c_half_event: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && gctrl.half && ghalf);
    c_collision: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (ram_coll_in != 8'h00) && wr && hit_coll);
    c_cont_pingpong: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        gnt_valid && glast && gctrl.mode == dcs_pkg::MODE_CONT_PP);

endmodule

`default_nettype wire

// ===== dcs_pkg.sv
// dcs_pkg: constants and types of the eight-channel dma status and count block
// assumes a 32-bit apb slave with 12-bit byte addresses and one clock
package dcs_pkg;

    localparam int          NUM_CH       = 8;
    localparam int          ADDR_W       = 12;
    localparam int          CNT_W        = 10;

    // channel window: channel n at byte address n * 32
    localparam int          CH_SEL_LSB   = 5;
    localparam logic [3:0]  CH_AREA      = 4'h0;
    localparam logic [4:0]  OFF_CTRL     = 5'h00;
    localparam logic [4:0]  OFF_PAD      = 5'h04;
    localparam logic [4:0]  OFF_CNT      = 5'h08;
    localparam logic [4:0]  OFF_STA      = 5'h0c;
    localparam logic [4:0]  OFF_STB      = 5'h10;

    // shared registers
    localparam logic [11:0] OFF_COLL     = 12'h100;
    localparam logic [11:0] OFF_BUFSTAT  = 12'h104;
    localparam logic [11:0] OFF_RECENT   = 12'h108;
    localparam logic [11:0] OFF_ISTAT    = 12'h10c;
    localparam logic [11:0] OFF_IMASK    = 12'h110;

    // field positions
    localparam int          PCOL_LSB     = 8;
    localparam int          LAST_CH_LSB  = 8;

    // reset values
    localparam logic [15:0] WORD16_RST   = 16'h0000;
    localparam logic [9:0]  CNT_RST      = 10'h000;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [3:0]  LAST_CH_RST  = 4'hf;

    // ram address steps
    localparam logic [15:0] STEP_BYTE    = 16'h0001;
    localparam logic [15:0] STEP_WORD    = 16'h0002;

    typedef enum logic [1:0] {
        MODE_CONT       = 2'b00,
        MODE_ONESHOT    = 2'b01,
        MODE_CONT_PP    = 2'b10,
        MODE_ONESHOT_PP = 2'b11
    } dcs_mode_t;

    localparam logic [1:0]  AMODE_POSTINC = 2'b00;

    // control word: en 15, size 14, dir 13, half 12, nullw 11, amode 5:4, mode 1:0
    typedef struct packed {
        logic      en;
        logic      byte_size;
        logic      dir;
        logic      half;
        logic      nullw;
        logic [1:0] amode;
        dcs_mode_t mode;
    } dcs_ctrl_t;

    localparam dcs_ctrl_t CTRL_RST = '{en: 1'b0, byte_size: 1'b0, dir: 1'b0, half: 1'b0,
                                       nullw: 1'b0, amode: 2'h0, mode: MODE_CONT};

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [15:0] ram_addr;
        logic [15:0] periph_addr;
        logic        dir;
        logic        byte_size;
        logic        nullw;
    } dcs_xfer_t;

endpackage

// ===== dcs_periph_model.sv
// dcs_periph_model: peripheral side that raises transfer requests and collision events
// assumes the clock of the dma block; the bench calls its tasks to make traffic
`timescale 1ns/10ps
`default_nettype none

module dcs_periph_model (
    // clock
    input  wire logic  clk_in,
    // towards the dma block
    output logic [7:0] req_out,
    output logic [7:0] pcoll_out,
    output logic [7:0] rcoll_out
);
    initial begin
        req_out   = 8'h00;
        pcoll_out = 8'h00;
        rcoll_out = 8'h00;
    end

    // one-cycle request of one channel
    task automatic request(input logic [2:0] ch);
        @(posedge clk_in);
        req_out <= 8'h01 << ch;
        @(posedge clk_in);
        req_out <= 8'h00;
    endtask

    // one-cycle collision events, peripheral and ram side
    task automatic collide(input logic [7:0] p, input logic [7:0] r);
        @(posedge clk_in);
        pcoll_out <= p;
        rcoll_out <= r;
        @(posedge clk_in);
        pcoll_out <= 8'h00;
        rcoll_out <= 8'h00;
    endtask
endmodule

`default_nettype wire

// ===== dcs_top_tb_top.sv
// dcs_top_tb_top: self-checking bench for the dma status and count block
// assumes zero-wait apb slave and transfers two edges after a request
`timescale 1ns/10ps
`default_nettype none

module dcs_top_tb_top;
    logic               sys_clk;
    logic               reset_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [7:0]         req;
    logic [7:0]         pcoll;
    logic [7:0]         rcoll;
    dcs_pkg::dcs_xfer_t xfer;
    logic               irq;
    int                 n_mismatch = 0;
    int                 checks_done = 0;
    int                 cyc = 0;

    dcs_top dcs_top_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .req_in(req), .periph_coll_in(pcoll), .ram_coll_in(rcoll), .xfer_out(xfer),
        .irq_out(irq));
    dcs_periph_model dcs_periph_model_i (.clk_in(sys_clk), .req_out(req), .pcoll_out(pcoll), .rcoll_out(rcoll));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] ch_a(input logic [2:0] ch, input logic [4:0] off);
        return {dcs_pkg::CH_AREA, ch, off};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {16'h0000, d}, q, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(q, exp, what);
    endtask

    // request one transfer and judge what comes out
    task automatic xfer_chk(input logic [2:0] ch, input logic [15:0] ram, input logic [15:0] pa, input logic d);
        int n;
        dcs_periph_model_i.request(ch);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (xfer.valid !== 1'b1 && n < 8);
        check({29'h0, xfer.valid, 2'h0}, 32'h4, "transfer seen");
        check({13'h0, xfer.chan, xfer.ram_addr}, {13'h0, ch, ram}, "channel and ram address");
        check({15'h0, xfer.dir, xfer.periph_addr}, {15'h0, d, pa}, "direction and target");
    endtask

    task automatic t_reset();
        int n;
        rd_chk(ch_a(3'h0, dcs_pkg::OFF_PAD), 32'h0, "target reset");
        rd_chk(ch_a(3'h7, dcs_pkg::OFF_CNT), 32'h0, "count reset");
        rd_chk(dcs_pkg::OFF_COLL, 32'h0, "collision reset");
        rd_chk(dcs_pkg::OFF_BUFSTAT, 32'h0000_0f00, "last channel none");
        rd_chk(dcs_pkg::OFF_RECENT, 32'h0, "recent reset");
        dcs_periph_model_i.request(3'h5);
        n = 0;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            if (xfer.valid !== 1'b0) n++;
        end
        check(n, 0, "disabled channel ignored");
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        wr(ch_a(3'h3, dcs_pkg::OFF_PAD), 16'ha5c3);
        rd_chk(ch_a(3'h3, dcs_pkg::OFF_PAD), 32'h0000_a5c3, "target rw");
        wr(ch_a(3'h6, dcs_pkg::OFF_CNT), 16'hffff);
        rd_chk(ch_a(3'h6, dcs_pkg::OFF_CNT), 32'h0000_03ff, "count width");
        wr(dcs_pkg::OFF_BUFSTAT, 16'h00ff);
        rd_chk(dcs_pkg::OFF_BUFSTAT, 32'h0000_0f00, "buffer status read only");
        apb(1'b0, 12'h200, 32'h0, q, e);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped reads zero");
        $display("test registers done");
    endtask

    task automatic t_coll();
        dcs_periph_model_i.collide(8'h04, 8'h20);
        rd_chk(dcs_pkg::OFF_COLL, 32'h0000_0420, "collision flags set");
        wr(dcs_pkg::OFF_COLL, 16'hffff);
        rd_chk(dcs_pkg::OFF_COLL, 32'h0000_0420, "ones ignored");
        wr(dcs_pkg::OFF_COLL, 16'h0000);
        rd_chk(dcs_pkg::OFF_COLL, 32'h0, "zeros clear");
        $display("test collisions done");
    endtask

    task automatic t_block();
        wr(ch_a(3'h1, dcs_pkg::OFF_PAD), 16'h1234);
        wr(ch_a(3'h1, dcs_pkg::OFF_CNT), 16'h0002);
        wr(ch_a(3'h1, dcs_pkg::OFF_STA), 16'h0100);
        wr(ch_a(3'h1, dcs_pkg::OFF_STB), 16'h0200);
        wr(dcs_pkg::OFF_IMASK, 16'h0002);
        wr(ch_a(3'h1, dcs_pkg::OFF_CTRL), 16'ha003);
        xfer_chk(3'h1, 16'h0100, 16'h1234, 1'b1);
        check({31'h0, irq}, 32'h0, "no early block end");
        xfer_chk(3'h1, 16'h0102, 16'h1234, 1'b1);
        xfer_chk(3'h1, 16'h0104, 16'h1234, 1'b1);
        @(posedge sys_clk);
        #1;
        check({31'h0, irq}, 32'h1, "block end interrupt");
        rd_chk(dcs_pkg::OFF_BUFSTAT, 32'h0000_0102, "last channel and buffer");
        rd_chk(dcs_pkg::OFF_RECENT, 32'h0000_0104, "recent address");
        rd_chk(dcs_pkg::OFF_ISTAT, 32'h0000_0002, "interrupt status");
        #1;
        check({31'h0, irq}, 32'h0, "interrupt cleared by read");
        xfer_chk(3'h1, 16'h0200, 16'h1234, 1'b1);
        $display("test block done");
    endtask

    task automatic t_half();
        wr(ch_a(3'h0, dcs_pkg::OFF_CNT), 16'h0003);
        wr(ch_a(3'h0, dcs_pkg::OFF_STA), 16'h0040);
        wr(dcs_pkg::OFF_IMASK, 16'h0001);
        wr(ch_a(3'h0, dcs_pkg::OFF_CTRL), 16'h9000);
        xfer_chk(3'h0, 16'h0040, 16'h0000, 1'b0);
        @(posedge sys_clk);
        #1;
        check({31'h0, irq}, 32'h0, "not yet half");
        xfer_chk(3'h0, 16'h0042, 16'h0000, 1'b0);
        @(posedge sys_clk);
        #1;
        check({31'h0, irq}, 32'h1, "half block interrupt");
        rd_chk(dcs_pkg::OFF_BUFSTAT, 32'h0000_0002, "last channel zero");
        $display("test half done");
    endtask

    task automatic t_modes();
        wr(ch_a(3'h2, dcs_pkg::OFF_STA), 16'h0300);
        wr(ch_a(3'h2, dcs_pkg::OFF_CNT), 16'h0000);
        wr(ch_a(3'h2, dcs_pkg::OFF_CTRL), 16'hc811);
        xfer_chk(3'h2, 16'h0300, 16'h0000, 1'b0);
        check({30'h0, xfer.byte_size, xfer.nullw}, 32'h3, "byte null write");
        rd_chk(ch_a(3'h2, dcs_pkg::OFF_CTRL), 32'h0000_4811, "one-shot stops");
        wr(ch_a(3'h3, dcs_pkg::OFF_STA), 16'h0500);
        wr(ch_a(3'h3, dcs_pkg::OFF_STB), 16'h0600);
        wr(ch_a(3'h3, dcs_pkg::OFF_CNT), 16'h0000);
        wr(ch_a(3'h3, dcs_pkg::OFF_CTRL), 16'h8002);
        xfer_chk(3'h3, 16'h0500, 16'ha5c3, 1'b0);
        xfer_chk(3'h3, 16'h0600, 16'ha5c3, 1'b0);
        xfer_chk(3'h3, 16'h0500, 16'ha5c3, 1'b0);
        check({30'h0, xfer.byte_size, xfer.nullw}, 32'h0, "word plain write");
        $display("test modes done");
    endtask

    task automatic t_rst2();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        check({31'h0, irq}, 32'h0, "no interrupt after reset");
        rd_chk(dcs_pkg::OFF_BUFSTAT, 32'h0000_0f00, "status after reset");
        rd_chk(ch_a(3'h3, dcs_pkg::OFF_CTRL), 32'h0, "control after reset");
        $display("test second reset done");
    endtask

    initial begin
        reset_n = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_coll();
        t_block();
        t_half();
        t_modes();
        t_rst2();
        test_done();
    end
endmodule

`default_nettype wire
